//--- design/rtc_bcd_calendar.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_bcd_calendar
  import rtc_pkg::*;
(
  input var rtc_time_s cur,
  output rtc_time_s nxt
);

  // {carry, next value}; wraps from last to first
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) begin
      bcd_step = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // BCD value modulo 4 is zero: 10t+o mod 4 equals 2t+o mod 4
  function automatic logic div4(input logic [7:0] v);
    logic [1:0] m;
    m = {v[4], 1'b0} + v[1:0];
    div4 = (m == 2'b00);
  endfunction

  logic leap;
  logic [7:0] last_day;
  logic [8:0] s_sec, s_min, s_hour, s_date, s_wday, s_mon, s_year, s_cent;

  always_comb begin
    leap = div4(cur.year) && ((cur.year != 8'h00) || div4(cur.cent)); // RULE_24
    case (cur.month)
      8'h02: last_day = leap ? 8'h29 : 8'h28; // RULE_24
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
    s_sec = bcd_step(cur.sec, 8'h59, 8'h00); // RULE_01
    s_min = bcd_step(cur.min, 8'h59, 8'h00);
    s_hour = bcd_step(cur.hour, 8'h23, 8'h00);
    s_date = bcd_step(cur.date, last_day, 8'h01);
    s_wday = bcd_step(cur.wday, 8'h07, 8'h01);
    s_mon = bcd_step(cur.month, 8'h12, 8'h01);
    s_year = bcd_step(cur.year, 8'h99, 8'h00);
    s_cent = bcd_step(cur.cent, 8'h99, 8'h00);
    nxt = cur;
    nxt.sec = s_sec[7:0]; // RULE_24
    if (s_sec[8]) begin
      nxt.min = s_min[7:0];
      if (s_min[8]) begin
        nxt.hour = s_hour[7:0];
        if (s_hour[8]) begin
          nxt.wday = s_wday[7:0];
          nxt.date = s_date[7:0];
          if (s_date[8]) begin
            nxt.month = s_mon[7:0];
            if (s_mon[8]) begin
              nxt.year = s_year[7:0];
              if (s_year[8]) begin
                nxt.cent = s_cent[7:0]; // RULE_01
              end
            end
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- design/rtc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.svh"

module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned OSC_CHECK_CYCLES = `RTC_OSC_CHECK_MS * (`RTC_REF_CLK_HZ / 1000)
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic [14:0] ADDR,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic OE_N,
  input wire logic [7:0] DQ_I,
  output logic [7:0] DQ_O,
  output logic DQ_OE,
  input wire logic XTAL_TICK,
  output logic OSC_ENABLE,
  output logic INT_OUT
);

  // ==========================================================
  // Register read mux
  function automatic logic [7:0] read_byte(input rtc_state_s s, input logic [14:0] a);
    case (a)
      `RTC_ADDR_FLAGS: read_byte = {s.watchdog_flag, s.af, 1'b0, s.oscillator_failed_flag, 1'b0, s.cal_test, s.wr_en,
                                    s.rd_hold};
      `RTC_ADDR_CENT: read_byte = s.hold.cent;
      `RTC_ADDR_ALM_SEC: read_byte = s.alm_sec;
      `RTC_ADDR_ALM_MIN: read_byte = s.alm_min;
      `RTC_ADDR_ALM_HOUR: read_byte = s.alm_hour;
      `RTC_ADDR_ALM_DATE: read_byte = s.alm_date;
      `RTC_ADDR_INTR: read_byte = s.intr;
      // Strobe bit always reads back as zero
      `RTC_ADDR_WDOG: read_byte = {1'b0, s.wd_lock, s.wd_load};
      `RTC_ADDR_CAL: read_byte = s.cal;
      `RTC_ADDR_SEC: read_byte = s.hold.sec;
      `RTC_ADDR_MIN: read_byte = s.hold.min;
      `RTC_ADDR_HOUR: read_byte = s.hold.hour;
      `RTC_ADDR_WDAY: read_byte = s.hold.wday;
      `RTC_ADDR_DATE: read_byte = s.hold.date;
      `RTC_ADDR_MONTH: read_byte = s.hold.month;
      `RTC_ADDR_YEAR: read_byte = s.hold.year;
      default: read_byte = 8'h00;
    endcase
  endfunction

  // Alarm field compare with its mask bit
  function automatic logic alm_field(input logic [7:0] alm, input logic [7:0] cur);
    alm_field = alm[`RTC_ALM_MASK] || (alm[6:0] == cur[6:0]);
  endfunction

  // ==========================================================
  // State
  rtc_state_s s_ff;
  rtc_state_s nxt_s;
  rtc_bus_s bus;
  rtc_time_s cal_next;

  logic hit;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic xt;
  logic sec_wrap;
  logic wd_tick;
  logic adj_sec;
  logic [15:0] sec_len;
  logic load_base;
  logic alm_hit;
  logic wd_hit;
  logic flag_rd;

  assign bus = '{addr: ADDR, ce_n: CE_N, we_n: WE_N, oe_n: OE_N, wdata: DQ_I};

  rtc_bcd_calendar u_cal (
    .cur(s_ff.live),
    .nxt(cal_next)
  );

  always_comb begin
    nxt_s = s_ff;
    hit = (bus.addr[14:4] == `RTC_ADDR_PAGE) && !bus.ce_n;
    rd_act = hit && bus.we_n;
    wr_act = hit && !bus.we_n;
    rd_start = rd_act && !s_ff.rd_prev;
    wr_start = wr_act && !s_ff.wr_prev;
    flag_rd = rd_start && (bus.addr == `RTC_ADDR_FLAGS);
    // Oscillator edges count only while it is enabled
    xt = XTAL_TICK && !s_ff.cal[`RTC_CAL_OFF]; // RULE_06
    adj_sec = (s_ff.cal_sec == 6'd0) && (s_ff.cal_min < {s_ff.cal[4:0], 1'b0}); // RULE_11
    if (adj_sec && s_ff.cal[`RTC_CAL_SIGN]) begin
      sec_len = `RTC_XTAL_PER_SEC - `RTC_CAL_FAST_SUB; // RULE_10
    end else if (adj_sec) begin
      sec_len = `RTC_XTAL_PER_SEC + `RTC_CAL_SLOW_ADD; // RULE_10
    end else begin
      sec_len = `RTC_XTAL_PER_SEC;
    end
    sec_wrap = xt && (s_ff.presc == sec_len - 16'd1);
    wd_tick = xt && (s_ff.raw == `RTC_WD_DIV_LAST); // RULE_18
    load_base = 1'b0;
    alm_hit = 1'b0;
    wd_hit = 1'b0;

    if (SRST) begin
      nxt_s = '0;
      nxt_s.live = '{cent: `RTC_RST_CENT, year: `RTC_RST_ZERO, month: `RTC_RST_DATE,
                     wday: `RTC_RST_DATE, date: `RTC_RST_DATE, hour: `RTC_RST_ZERO,
                     min: `RTC_RST_ZERO, sec: `RTC_RST_ZERO};
      nxt_s.base = nxt_s.live;
      nxt_s.hold = nxt_s.live;
      nxt_s.alm_sec = `RTC_RST_ALARM;
      nxt_s.alm_min = `RTC_RST_ALARM;
      nxt_s.alm_hour = `RTC_RST_ALARM;
      nxt_s.alm_date = `RTC_RST_ALARM;
      nxt_s.cal = `RTC_RST_CAL; // RULE_06
      nxt_s.intr = `RTC_RST_INTR;
      nxt_s.chk = RTC_CHK_WAIT;
    end else begin
      nxt_s.rd_prev = rd_act;
      nxt_s.wr_prev = wr_act;

      // ========================================================
      // Host writes, one per falling access
      if (wr_start) begin
        case (bus.addr)
          `RTC_ADDR_FLAGS: begin
            nxt_s.rd_hold = bus.wdata[`RTC_FLG_R]; // RULE_02
            nxt_s.wr_en = bus.wdata[`RTC_FLG_W]; // RULE_04
            // Test and fail bits only move inside a permit window
            if (s_ff.wr_en) begin
              nxt_s.cal_test = bus.wdata[`RTC_FLG_CAL]; // RULE_09
              if (!bus.wdata[`RTC_FLG_OSCILLATOR_FAILED_FLAG]) begin
                nxt_s.oscillator_failed_flag = 1'b0; // RULE_09
              end
            end
            if (s_ff.wr_en && !bus.wdata[`RTC_FLG_W]) begin
              load_base = 1'b1; // RULE_05
            end
          end
          `RTC_ADDR_ALM_SEC: begin
            if (s_ff.wr_en) begin
              nxt_s.alm_sec = bus.wdata; // RULE_16
            end
          end
          `RTC_ADDR_ALM_MIN: begin
            if (s_ff.wr_en) begin
              nxt_s.alm_min = bus.wdata; // RULE_16
            end
          end
          `RTC_ADDR_ALM_HOUR: begin
            if (s_ff.wr_en) begin
              nxt_s.alm_hour = bus.wdata; // RULE_16
            end
          end
          `RTC_ADDR_ALM_DATE: begin
            if (s_ff.wr_en) begin
              nxt_s.alm_date = bus.wdata; // RULE_16
            end
          end
          `RTC_ADDR_INTR: nxt_s.intr = bus.wdata & `RTC_INT_MASK;
          `RTC_ADDR_WDOG: begin
            nxt_s.wd_lock = bus.wdata[`RTC_WD_LOCK];
            if (!bus.wdata[`RTC_WD_LOCK]) begin
              nxt_s.wd_load = bus.wdata[5:0]; // RULE_21
            end
          end
          `RTC_ADDR_CAL: nxt_s.cal = {bus.wdata[7], 1'b0, bus.wdata[5:0]}; // RULE_10
          `RTC_ADDR_CENT: begin
            if (s_ff.wr_en) begin
              nxt_s.base.cent = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_SEC: begin
            if (s_ff.wr_en) begin
              nxt_s.base.sec = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_MIN: begin
            if (s_ff.wr_en) begin
              nxt_s.base.min = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_HOUR: begin
            if (s_ff.wr_en) begin
              nxt_s.base.hour = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_WDAY: begin
            if (s_ff.wr_en) begin
              nxt_s.base.wday = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_DATE: begin
            if (s_ff.wr_en) begin
              nxt_s.base.date = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_MONTH: begin
            if (s_ff.wr_en) begin
              nxt_s.base.month = bus.wdata; // RULE_04
            end
          end
          `RTC_ADDR_YEAR: begin
            if (s_ff.wr_en) begin
              nxt_s.base.year = bus.wdata; // RULE_04
            end
          end
          default: ;
        endcase
      end

      // ========================================================
      // Power-on oscillator check
      case (s_ff.chk)
        RTC_CHK_WAIT: begin
          if (s_ff.cal[`RTC_CAL_OFF] || XTAL_TICK) begin
            nxt_s.chk = RTC_CHK_DONE;
          end else if (s_ff.chk_cnt == 20'(OSC_CHECK_CYCLES - 1)) begin
            nxt_s.oscillator_failed_flag = 1'b1; // RULE_07
            load_base = 1'b1; // RULE_08
            nxt_s.chk = RTC_CHK_DONE;
          end else begin
            nxt_s.chk_cnt = s_ff.chk_cnt + 20'd1;
          end
        end
        RTC_CHK_DONE: nxt_s.chk = RTC_CHK_DONE;
        default: nxt_s.chk = RTC_CHK_WAIT;
      endcase

      // ========================================================
      // Timekeeping and calibration
      if (xt) begin
        nxt_s.raw = s_ff.raw + 10'd1;
        nxt_s.presc = sec_wrap ? 16'd0 : s_ff.presc + 16'd1;
      end
      if (sec_wrap) begin
        // Calibration cycle runs on its own so setting time cannot skip it
        if (s_ff.cal_sec == `RTC_CAL_LAST_SEC) begin
          nxt_s.cal_sec = 6'd0;
          nxt_s.cal_min = s_ff.cal_min + 6'd1; // RULE_11
        end else begin
          nxt_s.cal_sec = s_ff.cal_sec + 6'd1;
        end
      end
      if (load_base) begin
        nxt_s.live = nxt_s.base; // RULE_05 RULE_08
        nxt_s.presc = 16'd0;
      end else if (sec_wrap) begin
        nxt_s.live = cal_next; // RULE_01 RULE_24
      end
      nxt_s.alm_chk = sec_wrap && !load_base;

      // Visible copy follows live only while capture is off
      if (!s_ff.rd_hold) begin
        nxt_s.hold = s_ff.live; // RULE_02 RULE_03
      end

      // ========================================================
      // Alarm
      alm_hit = s_ff.alm_chk && alm_field(s_ff.alm_sec, s_ff.live.sec) // RULE_13 RULE_14
                && alm_field(s_ff.alm_min, s_ff.live.min)
                && alm_field(s_ff.alm_hour, s_ff.live.hour)
                && alm_field(s_ff.alm_date, s_ff.live.date);
      // Setting beats a clearing read in the same cycle
      nxt_s.af = (s_ff.af && !flag_rd) || alm_hit; // RULE_13 RULE_17

      // ========================================================
      // Watchdog
      if (wr_start && (bus.addr == `RTC_ADDR_WDOG) && bus.wdata[`RTC_WD_STROBE]) begin
        nxt_s.wd_cnt = nxt_s.wd_load; // RULE_20
      end else if (nxt_s.wd_load == 6'd0) begin
        nxt_s.wd_cnt = 6'd0; // RULE_22
      end else if (wd_tick) begin
        if (s_ff.wd_cnt <= 6'd1) begin
          wd_hit = 1'b1; // RULE_19
          nxt_s.wd_cnt = s_ff.wd_load;
        end else begin
          nxt_s.wd_cnt = s_ff.wd_cnt - 6'd1; // RULE_18
        end
      end
      nxt_s.watchdog_flag = (s_ff.watchdog_flag && !flag_rd) || wd_hit; // RULE_17 RULE_19

      // ========================================================
      // Pins
      nxt_s.dq_o = rd_act ? read_byte(s_ff, bus.addr) : 8'h00;
      nxt_s.dq_oe = rd_act && !bus.oe_n;
      nxt_s.osc_en = !nxt_s.cal[`RTC_CAL_OFF]; // RULE_06
      if (s_ff.cal_test) begin
        nxt_s.int_o = s_ff.raw[`RTC_TEST_BIT]; // RULE_12
      end else begin
        nxt_s.int_o = (s_ff.af && s_ff.intr[`RTC_INT_AIE]) // RULE_23
                      || (s_ff.watchdog_flag && s_ff.intr[`RTC_INT_WIE]); // RULE_23
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || CLK_EN) begin
      s_ff <= nxt_s;
    end
  end

  assign DQ_O = s_ff.dq_o;
  assign DQ_OE = s_ff.dq_oe;
  assign OSC_ENABLE = s_ff.osc_en;
  assign INT_OUT = s_ff.int_o;

endmodule

`default_nettype wire

//--- design/rtc_map.svh
// Overview of operation
// (RULE_01) Count seconds up to year 9999, full calendar
// (RULE_02) Capture bit freezes visible time, clock runs on
// (RULE_03) Clearing capture refreshes all time registers together
// (RULE_04) Update-permit lets host write BCD base time
// (RULE_05) Clearing update-permit loads base time into counters
// (RULE_06) Oscillator-off bit: 0 runs, 1 stops, resets 0
// (RULE_07) Enabled oscillator silent 5 ms sets failed flag
// (RULE_08) Failed flag restores counters to base time
// (RULE_09) Host brackets flag writes with update-permit set/clear
// (RULE_10) Five-bit calibration magnitude, bit 5 gives direction
// (RULE_11) 64-minute cycle, 2N minutes get one adjusted second
// (RULE_12) Frequency test drives interrupt at 512 Hz uncalibrated
// (RULE_13) Alarm match sets alarm flag, optional interrupt
// (RULE_14) Alarm register MSB masks that field out
// (RULE_15) Host keeps seconds alarm mask bit at zero
// (RULE_16) Alarm writes need update-permit, alarms are volatile
// (RULE_17) Reading flags clears alarm and watchdog flags
// (RULE_18) Watchdog counts 32 Hz ticks, stops with oscillator
// (RULE_19) Watchdog reaching zero sets flag, optional interrupt
// (RULE_20) Strobe reloads watchdog from load value
// (RULE_21) Load field written only with write-lock bit clear
// (RULE_22) Zero load value disables the watchdog
// (RULE_23) Each source drives interrupt only when enabled
// (RULE_24) BCD counters cascade with month lengths, leap years
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ==========================================================
// Register addresses
`define RTC_ADDR_PAGE 11'h7ff
`define RTC_ADDR_FLAGS 15'h7ff0
`define RTC_ADDR_CENT 15'h7ff1
`define RTC_ADDR_ALM_SEC 15'h7ff2
`define RTC_ADDR_ALM_MIN 15'h7ff3
`define RTC_ADDR_ALM_HOUR 15'h7ff4
`define RTC_ADDR_ALM_DATE 15'h7ff5
`define RTC_ADDR_INTR 15'h7ff6
`define RTC_ADDR_WDOG 15'h7ff7
`define RTC_ADDR_CAL 15'h7ff8
`define RTC_ADDR_SEC 15'h7ff9
`define RTC_ADDR_MIN 15'h7ffa
`define RTC_ADDR_HOUR 15'h7ffb
`define RTC_ADDR_WDAY 15'h7ffc
`define RTC_ADDR_DATE 15'h7ffd
`define RTC_ADDR_MONTH 15'h7ffe
`define RTC_ADDR_YEAR 15'h7fff

// ==========================================================
// Field positions
`define RTC_FLG_WDF 7
`define RTC_FLG_AF 6
`define RTC_FLG_OSCILLATOR_FAILED_FLAG 4
`define RTC_FLG_CAL 2
`define RTC_FLG_W 1
`define RTC_FLG_R 0
`define RTC_CAL_OFF 7
`define RTC_CAL_SIGN 5
`define RTC_WD_STROBE 7
`define RTC_WD_LOCK 6
`define RTC_INT_WIE 7
`define RTC_INT_AIE 6
`define RTC_INT_MASK 8'hec
`define RTC_ALM_MASK 7

// ==========================================================
// Reset values
`define RTC_RST_CAL 8'h00
`define RTC_RST_INTR 8'h00
`define RTC_RST_ALARM 8'h00
`define RTC_RST_DATE 8'h01
`define RTC_RST_ZERO 8'h00
`define RTC_RST_CENT 8'h20

// ==========================================================
// Timing
`define RTC_REF_CLK_HZ 100000000
`define RTC_OSC_CHECK_MS 5
`define RTC_XTAL_PER_SEC 16'd32768
`define RTC_CAL_SLOW_ADD 16'd256
`define RTC_CAL_FAST_SUB 16'd128
`define RTC_CAL_LAST_SEC 6'd59
`define RTC_WD_DIV_LAST 10'h3ff
`define RTC_TEST_BIT 5

`endif

//--- design/rtc_pkg.sv
package rtc_pkg;

  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtc_time_s;

  typedef struct packed {
    logic [14:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [7:0] wdata;
  } rtc_bus_s;

  typedef enum logic [1:0] {
    RTC_CHK_WAIT = 2'b01,
    RTC_CHK_DONE = 2'b10
  } rtc_chk_e;

  typedef struct packed {
    rtc_time_s live;
    rtc_time_s base;
    rtc_time_s hold;
    logic [7:0] alm_sec;
    logic [7:0] alm_min;
    logic [7:0] alm_hour;
    logic [7:0] alm_date;
    logic [7:0] cal;
    logic [7:0] intr;
    logic [5:0] wd_load;
    logic wd_lock;
    logic [5:0] wd_cnt;
    logic watchdog_flag;
    logic af;
    logic oscillator_failed_flag;
    logic cal_test;
    logic wr_en;
    logic rd_hold;
    logic [15:0] presc;
    logic [9:0] raw;
    logic [5:0] cal_sec;
    logic [5:0] cal_min;
    logic alm_chk;
    rtc_chk_e chk;
    logic [19:0] chk_cnt;
    logic wr_prev;
    logic rd_prev;
    logic [7:0] dq_o;
    logic dq_oe;
    logic osc_en;
    logic int_o;
  } rtc_state_s;

endpackage

//--- test/rtc_alarm_watchdog_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch %s expected %h seen %h", nm, (exp), (got)); end end
module rtc_alarm_watchdog_core_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic xtal = 1'b0;
  logic clk_en = 1'b1;
  logic [14:0] addr;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic [7:0] dq_i;
  logic [7:0] dq_o;
  logic dq_oe;
  logic osc_en;
  logic int_out;
  logic [7:0] q;
  logic oe;
  int n_errors = 0;
  int num_checks = 0;

  always #5 ref_clk = ~ref_clk;

  rtc_host_model u_rtc_host_model (.clk(ref_clk), .dq_o(dq_o), .dq_oe(dq_oe), .addr(addr),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_i(dq_i));

  // Short oscillator check keeps the boot scenario brief
  rtc_core #(.OSC_CHECK_CYCLES(20)) u_rtc_core (
    .REF_CLK(ref_clk), .SRST(srst), .CLK_EN(clk_en), .ADDR(addr), .CE_N(ce_n),
    .WE_N(we_n), .OE_N(oe_n), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
    .XTAL_TICK(xtal), .OSC_ENABLE(osc_en), .INT_OUT(int_out));

  // ========
  // Helpers
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic ticks(input int n);
    @(posedge ref_clk);
    #1 xtal = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1 xtal = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
    u_rtc_host_model.rd(a, 1'b0, q, oe);
    `CHK($sformatf("reg %h", a), exp, q)
    `CHK("data enable", 1'b1, oe)
  endtask

  task automatic wait_int(input logic v);
    int i;
    for (i = 0; i < 8 && int_out !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("interrupt", v, int_out)
    if (int_out !== v) results();
  endtask

  // ========
  // Scenarios
  task automatic t_boot();
    rchk(`RTC_ADDR_CAL, 8'h00);
    `CHK("osc enable", 1'b1, osc_en)
    u_rtc_host_model.rd(15'h0100, 1'b0, q, oe);
    `CHK("unmapped", 9'h000, {oe, q})
    u_rtc_host_model.rd(`RTC_ADDR_CAL, 1'b1, q, oe);
    `CHK("gated enable", 1'b0, oe)
    repeat (30) @(posedge ref_clk);
    rchk(`RTC_ADDR_FLAGS, 8'h10);
    rchk(`RTC_ADDR_SEC, 8'h00);
    u_rtc_host_model.flag_write(8'h00);
    rchk(`RTC_ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_time();
    logic [14:0] ta[11] = '{`RTC_ADDR_SEC, `RTC_ADDR_MIN, `RTC_ADDR_HOUR, `RTC_ADDR_WDAY,
      `RTC_ADDR_DATE, `RTC_ADDR_MONTH, `RTC_ADDR_YEAR, `RTC_ADDR_CENT, `RTC_ADDR_ALM_MIN,
      `RTC_ADDR_ALM_HOUR, `RTC_ADDR_ALM_DATE};
    logic [7:0] tv[11] = '{8'h58, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h20,
      8'h80, 8'h80, 8'h80};
    logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h21};
    u_rtc_host_model.wr(`RTC_ADDR_SEC, 8'h11);
    u_rtc_host_model.wr(`RTC_ADDR_ALM_SEC, 8'h33);
    rchk(`RTC_ADDR_SEC, 8'h00);
    rchk(`RTC_ADDR_ALM_SEC, 8'h00);
    u_rtc_host_model.wr(`RTC_ADDR_FLAGS, 8'h02);
    foreach (ta[i]) begin
      u_rtc_host_model.wr(ta[i], tv[i]);
    end
    u_rtc_host_model.alarm_sec(8'h59);
    u_rtc_host_model.wr(`RTC_ADDR_FLAGS, 8'h00);
    u_rtc_host_model.wr(`RTC_ADDR_INTR, 8'h40);
    // First second after reset is shortened by 128 cycles
    u_rtc_host_model.wr(`RTC_ADDR_CAL, 8'h21);
    rchk(`RTC_ADDR_SEC, 8'h58);
    rchk(`RTC_ADDR_YEAR, 8'h99);
    ticks(32640);
    rchk(`RTC_ADDR_SEC, 8'h59);
    wait_int(1'b1);
    rchk(`RTC_ADDR_FLAGS, 8'h40);
    rchk(`RTC_ADDR_FLAGS, 8'h00);
    wait_int(1'b0);
    u_rtc_host_model.wr(`RTC_ADDR_FLAGS, 8'h01);
    ticks(32896);
    rchk(`RTC_ADDR_SEC, 8'h59);
    u_rtc_host_model.wr(`RTC_ADDR_FLAGS, 8'h00);
    foreach (rv[i]) begin
      rchk(ta[i], rv[i]);
    end
  endtask

  task automatic t_wdog();
    u_rtc_host_model.wr(`RTC_ADDR_INTR, 8'hc0);
    u_rtc_host_model.wr(`RTC_ADDR_WDOG, 8'h82);
    rchk(`RTC_ADDR_WDOG, 8'h02);
    ticks(2040);
    `CHK("early expiry", 1'b0, int_out)
    ticks(8);
    wait_int(1'b1);
    rchk(`RTC_ADDR_FLAGS, 8'h80);
    u_rtc_host_model.wr(`RTC_ADDR_WDOG, 8'h45);
    rchk(`RTC_ADDR_WDOG, 8'h42);
    u_rtc_host_model.wr(`RTC_ADDR_WDOG, 8'h00);
    u_rtc_host_model.wr(`RTC_ADDR_WDOG, 8'h80);
    ticks(3072);
    rchk(`RTC_ADDR_FLAGS, 8'h00);
    u_rtc_host_model.wr(`RTC_ADDR_INTR, 8'h40);
    u_rtc_host_model.wr(`RTC_ADDR_WDOG, 8'h81);
    ticks(1024);
    `CHK("masked watchdog", 1'b0, int_out)
    rchk(`RTC_ADDR_FLAGS, 8'h80);
  endtask

  task automatic t_cal();
    u_rtc_host_model.wr(`RTC_ADDR_CAL, 8'h25);
    rchk(`RTC_ADDR_CAL, 8'h25);
    u_rtc_host_model.flag_write(8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("test output", 1'b0, int_out)
    // Clock enable low must hold the divider still
    clk_en = 1'b0;
    ticks(32);
    `CHK("frozen output", 1'b0, int_out)
    clk_en = 1'b1;
    ticks(32);
    `CHK("test output", 1'b1, int_out)
    u_rtc_host_model.wr(`RTC_ADDR_CAL, 8'ha5);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("osc enable", 1'b0, osc_en)
    ticks(32);
    `CHK("test output", 1'b1, int_out)
    rchk(`RTC_ADDR_CAL, 8'ha5);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 srst = 1'b0;
    t_boot();
    t_time();
    t_wdog();
    t_cal();
    results();
  end

  // A hang counts as a failure
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    results();
  end
endmodule

bind rtc_core rtc_core_chk #(.OSC_CHECK_CYCLES(OSC_CHECK_CYCLES)) u_rtc_core_chk (
  .REF_CLK(REF_CLK), .SRST(SRST), .CLK_EN(CLK_EN), .ADDR(ADDR), .CE_N(CE_N), .WE_N(WE_N),
  .OE_N(OE_N), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .XTAL_TICK(XTAL_TICK),
  .OSC_ENABLE(OSC_ENABLE), .INT_OUT(INT_OUT));
`default_nettype wire

//--- test/rtc_core_props.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Port checker
module rtc_core_chk #(
  parameter int unsigned OSC_CHECK_CYCLES = 500000
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic [14:0] ADDR,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic OE_N,
  input wire logic [7:0] DQ_I,
  input wire logic [7:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic XTAL_TICK,
  input wire logic OSC_ENABLE,
  input wire logic INT_OUT
);
  logic hit;
  logic rd;
  logic wr;
  logic take;
  logic cal_wr;
  logic wr_prev_ff;

  assign hit = CLK_EN && !CE_N && (ADDR[14:4] == 11'h7ff);
  assign rd = hit && WE_N;
  assign wr = hit && !WE_N;
  // Only the first cycle of a write access is taken
  assign take = wr && !wr_prev_ff;
  assign cal_wr = take && (ADDR == 15'h7ff8);

  always_ff @(posedge REF_CLK) begin
    wr_prev_ff <= wr && !SRST;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // ========
  // Assertions
  rd_oe_a: assert property (rd && !OE_N |=> DQ_OE)
    else $error("read did not enable data output");
  oe_gate_a: assert property (rd && OE_N |=> !DQ_OE)
    else $error("data output enabled with output enable high");
  idle_zero_a: assert property (CLK_EN && !(!CE_N && WE_N) |=> !DQ_OE && DQ_O == 8'h00)
    else $error("data output not released after read");
  page_miss_a: assert property (CLK_EN && !CE_N && WE_N && ADDR[14:4] != 11'h7ff
    |=> !DQ_OE && DQ_O == 8'h00)
    else $error("register data outside the clock page");
  osc_off_a: assert property (cal_wr && DQ_I[7] |-> ##2 !OSC_ENABLE)
    else $error("oscillator still enabled after off write");
  osc_on_a: assert property (cal_wr && !DQ_I[7] |-> ##2 OSC_ENABLE)
    else $error("oscillator not enabled after on write");
  osc_hold_a: assert property (CLK_EN && !cal_wr && !$past(cal_wr) && !$past(SRST)
    && !$past(SRST, 2) |=> $stable(OSC_ENABLE))
    else $error("oscillator enable changed without a write");
  osc_boot_a: assert property ($fell(SRST) |=> ##1 OSC_ENABLE)
    else $error("oscillator not enabled after reset");
  strobe_zero_a: assert property (rd && ADDR == 15'h7ff7 |=> !DQ_O[7])
    else $error("watchdog strobe bit read back as one");
  cal_resv_a: assert property (rd && ADDR == 15'h7ff8 |=> !DQ_O[6])
    else $error("reserved calibration bit read back as one");

  cover property (rd && ADDR == 15'h7ff0);
  cover property ($rose(INT_OUT));
  cover property (cal_wr && DQ_I[7]);
endmodule
`default_nettype wire

//--- test/rtc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.svh"
// ========
// Host processor on the byte bus
module rtc_host_model (
  input wire logic clk,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  output logic [14:0] addr,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [7:0] dq_i
);
  initial begin
    addr = 15'h0000;
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    dq_i = 8'h00;
  end

  // Write is taken at access start, so data is valid in the first cycle
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    dq_i = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    @(posedge clk);
    #1;
    ce_n = 1'b1;
    we_n = 1'b1;
    dq_i = ~d;
    addr = ~a;
  endtask

  task automatic rd(input logic [14:0] a, input logic oe_off, output logic [7:0] q,
                    output logic oe);
    @(posedge clk);
    #1;
    addr = a;
    ce_n = 1'b0;
    we_n = 1'b1;
    oe_n = oe_off;
    @(posedge clk);
    #1;
    q = dq_o;
    oe = dq_oe;
    ce_n = 1'b1;
    oe_n = 1'b1;
    addr = ~a;
  endtask

  // Flag writes must be bracketed by the update-permit bit
  task automatic flag_write(input logic [7:0] d);
    wr(`RTC_ADDR_FLAGS, 8'h02);
    wr(`RTC_ADDR_FLAGS, d | 8'h02);
    wr(`RTC_ADDR_FLAGS, d & 8'hfd);
  endtask

  task automatic alarm_sec(input logic [7:0] d);
    wr(`RTC_ADDR_ALM_SEC, d & 8'h7f);
  endtask
endmodule
`default_nettype wire
